/* File: wdol_top.sv */
// watchdog with write-once option latches, avalon-mm register slave
// Contract
// RULE1 - option latches take first write per reset
// RULE2 - reset zeroes every latch bit but voltage mode
// RULE3 - voltage mode: power-on clear, once per power-on
// RULE4 - latches at 0x1E/0x1F, always readable
// RULE5 - oscillator runs in stop when bit set
// RULE6 - serial clock: one bus, zero oscillator
// RULE7 - rate bit: 8176 or 262128 cycles
// RULE8 - detector in stop only if enabled, powered
// RULE9 - reset-disable blocks resets, power-disable kills detector
// RULE10 - stop recovery hold 32 or 4096 cycles
// RULE11 - pin exit from stop always long
// RULE12 - stop disabled means illegal opcode reset
// RULE13 - disable bit stops watchdog resets
// RULE14 - 12-bit prescaler, 6-bit counter, overflow resets
// RULE15 - clear write zeroes counter, prescaler stages 12-5
// RULE16 - clear location reads reset vector low
// RULE17 - watchdog reset drives pin 32 cycles, sets cause
// RULE18 - stop removes clock, clears prescaler
// RULE19 - power-on clears prescaler after 4096 cycles
// RULE20 - internal reset, vector fetch clear counters; vector fetch clears only the prescaler here
// RULE21 - monitor test voltage or blank entry disables
// RULE22 - watchdog counts on in wait mode
// RULE23 - test voltage flag synchronised before use
`timescale 1ns/10ps
`default_nettype none
module wdol_top (
  input  wire logic               i_core_clk,
  input  wire logic               i_rst_b,
  input  wire logic               i_por_b,
  input  wire logic [17:0]        i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  input  wire logic [3:0]         i_avs_byteenable,
  output logic      [31:0]        o_avs_readdata,
  output logic                    o_avs_waitrequest,
  input  wire logic               i_crystal_ref_clock,
  input  wire logic               i_test_hv_irq,
  input  wire logic               i_test_hv_rst,
  input  wire logic               i_lvd_trip,
  input  wire logic [7:0]         i_reset_vector_lo,
  input  wire logic               i_stop_instr,
  input  wire logic               i_stop_mode,
  input  wire logic               i_stop_exit,
  input  wire logic               i_stop_exit_pin,
  input  wire logic               i_vector_fetch,
  input  wire logic               i_internal_reset,
  input  wire logic               i_monitor_mode,
  input  wire logic               i_break_state,
  input  wire logic               i_blank_vectors,
  output wdol_pkg::wdol_cfg_t     o_cfg,
  output logic                    o_osc_enable,
  output logic                    o_serial_clk_is_bus,
  output logic                    o_lvd_power_on,
  output logic                    o_lvd_reset_req,
  output logic                    o_cpu_hold,
  output logic                    o_stop_accept,
  output logic                    o_illegal_op_reset,
  output logic                    o_wdog_reset,
  output logic                    o_rst_pin_out,
  output logic                    o_rst_pin_oe_b
);
  wdol_pkg::wdol_state_t   st_r;
  wdol_pkg::wdol_state_t   st_nxt;
  wdol_pkg::wdol_por_t     por_r;
  wdol_pkg::wdol_por_t     por_nxt;
  logic [wdol_pkg::SYNC_W-1:0] sy;
  logic [15:0]             idx;
  logic                    req;
  logic                    acc_wr;
  logic                    acc_rd;
  logic                    tick;
  logic                    hv_irq;
  logic                    hv_rst;
  logic                    wd_active;
  logic                    por_pre_clr;
  logic [5:0]              cnt_term;
  logic                    wd_expire;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a == r);
  endfunction

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  wdol_sync u_sync (
    .i_core_clk (i_core_clk),
    .i_rst_b    (i_rst_b),
    .i_async    ({i_lvd_trip, i_test_hv_rst, i_test_hv_irq, i_crystal_ref_clock}),
    .o_sync     (sy)
  );

  // ****************************************************************
  // decode and watchdog enable
  // ****************************************************************
  // reference clock sampled; it must run well below half the core rate
  assign tick   = sy[wdol_pkg::SY_XCLK] & ~st_r.xclk_q;
  assign hv_irq = sy[wdol_pkg::SY_HV_IRQ]; // [RULE23]
  assign hv_rst = sy[wdol_pkg::SY_HV_RST]; // [RULE23]
  assign idx    = i_avs_address[17:2];
  assign req    = i_avs_read | i_avs_write;
  assign acc_wr = st_r.ack & i_avs_write & i_avs_byteenable[0];
  assign acc_rd = st_r.ack & i_avs_read;
  // wait mode is not an input: counting never depends on it [RULE22]
  assign wd_active = ~st_r.opt_one[wdol_pkg::B_WDOG_DIS] // [RULE13]
                   & ~(i_monitor_mode & (hv_irq | hv_rst)) // [RULE21]
                   & ~(i_break_state & hv_rst)
                   & ~por_r.blank_dis; // [RULE21]
  assign cnt_term  = st_r.opt_one[wdol_pkg::B_WDOG_RATE] ? wdol_pkg::CNT_FAST_TERM
                                                         : wdol_pkg::CNT_SLOW_TERM; // [RULE7]
  assign wd_expire = tick & ~i_stop_mode & (st_r.pre == wdol_pkg::PRE_TERM)
                   & (st_r.cnt == cnt_term); // [RULE14]
  assign por_pre_clr = por_r.por_pend & tick
                     & (por_r.por_cnt == (wdol_pkg::POR_CLR_TICKS - 13'h0001)); // [RULE19]

  // ****************************************************************
  // main next state
  // ****************************************************************
  always_comb begin
    st_nxt        = st_r;
    st_nxt.xclk_q = sy[wdol_pkg::SY_XCLK];
    // one wait state on every access
    st_nxt.ack    = req & ~st_r.ack;
    if (req & ~st_r.ack) begin
      st_nxt.rdata = 8'h00;
      if (hit(idx, wdol_pkg::IDX_OPT_ONE)) begin
        st_nxt.rdata = st_r.opt_one; // [RULE4]
        st_nxt.rdata[wdol_pkg::B_LVD_MODE] = por_r.lvd_mode;
      end else if (hit(idx, wdol_pkg::IDX_OPT_TWO)) begin
        st_nxt.rdata = st_r.opt_two; // [RULE4]
      end else if (hit(idx, wdol_pkg::IDX_CAUSE)) begin
        st_nxt.rdata[wdol_pkg::B_CAUSE_WD] = por_r.cause_wd;
      end else if (hit(idx, wdol_pkg::IDX_CLEAR)) begin
        st_nxt.rdata = i_reset_vector_lo; // [RULE16]
      end
    end
    if (acc_wr & hit(idx, wdol_pkg::IDX_OPT_ONE) & ~st_r.wr_one) begin
      st_nxt.opt_one = i_avs_writedata[7:0]; // [RULE1]
      st_nxt.opt_one[wdol_pkg::B_LVD_MODE] = 1'b0;
      st_nxt.wr_one  = 1'b1; // [RULE1]
    end
    if (acc_wr & hit(idx, wdol_pkg::IDX_OPT_TWO) & ~st_r.wr_two) begin
      st_nxt.opt_two = i_avs_writedata[7:0] & wdol_pkg::OPT_TWO_MASK; // [RULE1]
      st_nxt.wr_two  = 1'b1;
    end
    // prescaler and counter; no ticks reach them in stop [RULE18]
    if (tick & ~i_stop_mode) begin
      st_nxt.pre = st_r.pre + 12'h001; // [RULE14]
      if (st_r.pre == wdol_pkg::PRE_WRAP) begin
        st_nxt.cnt = st_r.cnt + 6'h01;
      end
    end
    if (i_stop_instr | i_vector_fetch | por_pre_clr) begin
      st_nxt.pre = 12'h000; // [RULE18] [RULE20] [RULE19]
    end
    if (acc_wr & hit(idx, wdol_pkg::IDX_CLEAR)) begin
      st_nxt.cnt = 6'h00; // [RULE15]
      st_nxt.pre = st_r.pre & wdol_pkg::PRE_KEEP; // [RULE15]
    end
    st_nxt.wd_fire = wd_active & wd_expire; // [RULE14] [RULE13]
    if (i_internal_reset | st_r.wd_fire) begin
      st_nxt.pre = 12'h000; // [RULE20]
      st_nxt.cnt = 6'h00;
    end
    // stop recovery hold
    if (i_stop_exit) begin
      st_nxt.rec_cnt = (st_r.opt_one[wdol_pkg::B_SHORT_REC] & ~i_stop_exit_pin)
                     ? wdol_pkg::REC_SHORT : wdol_pkg::REC_LONG; // [RULE10] [RULE11]
    end else if (tick & (st_r.rec_cnt != 13'h0000)) begin
      st_nxt.rec_cnt = st_r.rec_cnt - 13'h0001; // [RULE10]
    end
    st_nxt.ill_op  = i_stop_instr & ~st_r.opt_one[wdol_pkg::B_STOP_EN]; // [RULE12]
    st_nxt.stop_ok = i_stop_instr & st_r.opt_one[wdol_pkg::B_STOP_EN]; // [RULE12]
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r         <= '0; // [RULE2] [RULE20]
      st_r.opt_one <= wdol_pkg::OPT_RST; // [RULE2]
      st_r.opt_two <= wdol_pkg::OPT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // power-on domain: survives every reset but power-on
  // ****************************************************************
  always_comb begin
    por_nxt = por_r;
    if (acc_wr & hit(idx, wdol_pkg::IDX_OPT_ONE) & ~por_r.lvd_wr) begin
      por_nxt.lvd_mode = i_avs_writedata[wdol_pkg::B_LVD_MODE]; // [RULE3]
      por_nxt.lvd_wr   = 1'b1; // [RULE3]
    end
    if (i_monitor_mode & i_blank_vectors & ~hv_irq) begin
      por_nxt.blank_dis = 1'b1; // [RULE21]
    end
    if (por_r.por_pend & tick) begin
      por_nxt.por_cnt = por_r.por_cnt + 13'h0001;
      if (por_pre_clr) begin
        por_nxt.por_pend = 1'b0;
      end
    end
    // a watchdog event in the read cycle is kept
    por_nxt.cause_wd = (por_r.cause_wd & ~(acc_rd & hit(idx, wdol_pkg::IDX_CAUSE)))
                     | st_r.wd_fire; // [RULE17]
    if (st_r.wd_fire) begin
      por_nxt.drv_cnt = wdol_pkg::RST_PIN_TICKS; // [RULE17]
    end else if (tick & (por_r.drv_cnt != 6'h00)) begin
      por_nxt.drv_cnt = por_r.drv_cnt - 6'h01;
    end
  end

  // pin drive lives here so the reset it causes cannot cut it short
  always_ff @(posedge i_core_clk or negedge i_por_b) begin
    if (!i_por_b) begin
      por_r          <= '0; // [RULE3]
      por_r.por_pend <= 1'b1;
    end else begin
      por_r <= por_nxt;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_avs_waitrequest = req & ~st_r.ack;
  assign o_avs_readdata    = {24'h000000, st_r.rdata};
  always_comb begin
    o_cfg.osc_run_in_stop         = st_r.opt_two[wdol_pkg::B_OSC_RUN];
    o_cfg.serial_clock_source_sel = st_r.opt_two[wdol_pkg::B_SER_SRC];
    o_cfg.watchdog_rate_sel       = st_r.opt_one[wdol_pkg::B_WDOG_RATE];
    o_cfg.lvd_stop_enable         = st_r.opt_one[wdol_pkg::B_LVD_STOP];
    o_cfg.lvd_reset_disable       = st_r.opt_one[wdol_pkg::B_LVD_RSTD];
    o_cfg.lvd_power_disable       = st_r.opt_one[wdol_pkg::B_LVD_PWRD];
    o_cfg.lvd_voltage_mode        = por_r.lvd_mode; // [RULE3]
    o_cfg.short_stop_recovery     = st_r.opt_one[wdol_pkg::B_SHORT_REC];
    o_cfg.stop_enable             = st_r.opt_one[wdol_pkg::B_STOP_EN];
    o_cfg.watchdog_disable        = st_r.opt_one[wdol_pkg::B_WDOG_DIS];
  end
  assign o_osc_enable   = ~i_stop_mode | st_r.opt_two[wdol_pkg::B_OSC_RUN]; // [RULE5]
  // select only; the clock mux itself sits in the serial block
  assign o_serial_clk_is_bus = st_r.opt_two[wdol_pkg::B_SER_SRC]; // [RULE6]
  assign o_lvd_power_on = ~st_r.opt_one[wdol_pkg::B_LVD_PWRD]
                        & (~i_stop_mode | st_r.opt_one[wdol_pkg::B_LVD_STOP]); // [RULE8] [RULE9]
  assign o_lvd_reset_req = sy[wdol_pkg::SY_LVD] & ~st_r.opt_one[wdol_pkg::B_LVD_RSTD]
                         & ~st_r.opt_one[wdol_pkg::B_LVD_PWRD]; // [RULE9]
  assign o_cpu_hold         = (st_r.rec_cnt != 13'h0000); // [RULE10]
  assign o_stop_accept      = st_r.stop_ok;
  assign o_illegal_op_reset = st_r.ill_op; // [RULE12]
  assign o_wdog_reset       = st_r.wd_fire; // [RULE14]
  assign o_rst_pin_out      = 1'b0;
  assign o_rst_pin_oe_b     = (por_r.drv_cnt == 6'h00); // [RULE17]

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);

  sequence s_req_open;
    req & ~st_r.ack;
  endsequence
  sequence s_answer;
    ##1 ~o_avs_waitrequest;
  endsequence

  a_bus_answer_one: assert property (s_req_open |-> s_answer) // [RULE4]
    else $error("bus answer not after one wait state");
  a_latch_write_once: assert property (st_r.wr_one |=> $stable(st_r.opt_one)) // [RULE1]
    else $error("option latch changed after first write");
  a_clear_read_vec: assert property (s_req_open and i_avs_read and hit(idx, wdol_pkg::IDX_CLEAR)
    |=> o_avs_readdata[7:0] == $past(i_reset_vector_lo)) // [RULE16]
    else $error("clear location read not reset vector");
  a_clear_write_zero: assert property (acc_wr & hit(idx, wdol_pkg::IDX_CLEAR)
    & ~i_internal_reset & ~st_r.wd_fire |=> st_r.cnt == 6'h00 && st_r.pre[11:4] == 8'h00) // [RULE15]
    else $error("watchdog clear did not clear");
  a_expire_resets: assert property (wd_active & wd_expire |=> o_wdog_reset ##1 ~o_rst_pin_oe_b) // [RULE14]
    else $error("watchdog overflow did not reset");
  a_disabled_quiet: assert property (~wd_active |=> ~o_wdog_reset) // [RULE13]
    else $error("disabled watchdog fired");
  a_stop_illegal: assert property (i_stop_instr & ~o_cfg.stop_enable |=> o_illegal_op_reset & ~o_stop_accept) // [RULE12]
    else $error("disabled stop not illegal");
  a_pin_exit_long: assert property (i_stop_exit & i_stop_exit_pin |=> st_r.rec_cnt == wdol_pkg::REC_LONG) // [RULE11]
    else $error("pin stop exit not long recovery");
  a_short_recovery: assert property (i_stop_exit & ~i_stop_exit_pin & o_cfg.short_stop_recovery
    |=> st_r.rec_cnt == wdol_pkg::REC_SHORT) // [RULE10]
    else $error("short recovery length wrong");
  a_lvd_reset_block: assert property (o_cfg.lvd_reset_disable |-> ~o_lvd_reset_req) // [RULE9]
    else $error("detector reset not blocked");
  a_stop_clears_pre: assert property (i_stop_instr & ~acc_wr & ~i_internal_reset |=> st_r.pre == 12'h000) // [RULE18]
    else $error("stop did not clear prescaler");
endmodule // wdol_top
`default_nettype wire

/* File: wdol_pkg.sv */
// constants and types for the watchdog with option latches
package wdol_pkg;

  // ****************************************************************
  // register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [15:0] IDX_OPT_TWO = 16'h001E;
  localparam logic [15:0] IDX_OPT_ONE = 16'h001F;
  localparam logic [15:0] IDX_CAUSE   = 16'h0020;
  localparam logic [15:0] IDX_CLEAR   = 16'hFFFF;

  // ****************************************************************
  // option latch fields and reset values
  // ****************************************************************
  localparam int B_OSC_RUN   = 0;
  localparam int B_SER_SRC   = 1;
  localparam int B_WDOG_DIS  = 0;
  localparam int B_STOP_EN   = 1;
  localparam int B_SHORT_REC = 2;
  localparam int B_LVD_MODE  = 3;
  localparam int B_LVD_PWRD  = 4;
  localparam int B_LVD_RSTD  = 5;
  localparam int B_LVD_STOP  = 6;
  localparam int B_WDOG_RATE = 7;
  localparam int B_CAUSE_WD  = 0;
  localparam logic [7:0] OPT_RST      = 8'h00;
  localparam logic [7:0] OPT_TWO_MASK = 8'h03;

  // ****************************************************************
  // timing, in reference clock cycles
  // ****************************************************************
  localparam logic [11:0] PRE_TERM      = 12'hFF0;
  localparam logic [11:0] PRE_WRAP      = 12'hFFF;
  localparam logic [11:0] PRE_KEEP      = 12'h00F;
  localparam logic [5:0]  CNT_SLOW_TERM = 6'h3F;
  localparam logic [5:0]  CNT_FAST_TERM = 6'h01;
  localparam logic [12:0] REC_SHORT     = 13'h0020;
  localparam logic [12:0] REC_LONG      = 13'h1000;
  localparam logic [5:0]  RST_PIN_TICKS = 6'h20;
  localparam logic [12:0] POR_CLR_TICKS = 13'h1000;

  // ****************************************************************
  // synchroniser lanes
  // ****************************************************************
  localparam int SYNC_W    = 4;
  localparam int SY_XCLK   = 0;
  localparam int SY_HV_IRQ = 1;
  localparam int SY_HV_RST = 2;
  localparam int SY_LVD    = 3;

  typedef struct packed {
    logic osc_run_in_stop;
    logic serial_clock_source_sel;
    logic watchdog_rate_sel;
    logic lvd_stop_enable;
    logic lvd_reset_disable;
    logic lvd_power_disable;
    logic lvd_voltage_mode;
    logic short_stop_recovery;
    logic stop_enable;
    logic watchdog_disable;
  } wdol_cfg_t;

  typedef struct packed {
    logic        ack;
    logic [7:0]  rdata;
    logic [7:0]  opt_one;
    logic [7:0]  opt_two;
    logic        wr_one;
    logic        wr_two;
    logic        xclk_q;
    logic [11:0] pre;
    logic [5:0]  cnt;
    logic [12:0] rec_cnt;
    logic        ill_op;
    logic        stop_ok;
    logic        wd_fire;
  } wdol_state_t;

  typedef struct packed {
    logic        lvd_mode;
    logic        lvd_wr;
    logic        blank_dis;
    logic [12:0] por_cnt;
    logic        por_pend;
    logic        cause_wd;
    logic [5:0]  drv_cnt;
  } wdol_por_t;

  typedef struct packed {
    logic [SYNC_W-1:0] s1;
    logic [SYNC_W-1:0] s2;
  } wdol_sync_t;

endpackage

/* File: wdol_sync.sv */
// two flip-flop synchroniser for the pin inputs
`timescale 1ns/10ps
`default_nettype none
module wdol_sync (
  input  wire logic                      i_core_clk,
  input  wire logic                      i_rst_b,
  input  wire logic [wdol_pkg::SYNC_W-1:0] i_async,
  output logic      [wdol_pkg::SYNC_W-1:0] o_sync
);
  wdol_pkg::wdol_sync_t st_r;
  wdol_pkg::wdol_sync_t st_nxt;

  // first stage feeds only the second stage
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.s2;
endmodule // wdol_sync
`default_nettype wire

/* File: wdol_top_tb.sv */
// self-checking testbench for the watchdog with option latches
`timescale 1ns/10ps
`default_nettype none
module wdol_top_tb;
  logic                i_core_clk = 1'b0;
  logic                i_rst_b    = 1'b0;
  logic                i_por_b    = 1'b0;
  logic                rd = 1'b0, wr = 1'b0, xclk = 1'b0, trip = 1'b0, stop_instr = 1'b0;
  logic                stop_mode = 1'b0, stop_exit = 1'b0, exit_pin = 1'b0, vfetch = 1'b0, int_rst = 1'b0;
  logic                hv_irq = 1'b0, hv_rst = 1'b0, mon = 1'b0, brk = 1'b0, blank = 1'b0;
  logic [17:0]         addr  = 18'h00000;
  logic [31:0]         wdata = 32'h00000000;
  logic [3:0]          be    = 4'hF;
  logic [1:0]          ph    = 2'h0;
  logic [31:0]         rdata;
  logic                wreq, osc_en, ser_bus, lvd_on, lvd_req, hold, stop_ok, ill, wd_rst, pin_out, pin_oe_b;
  wdol_pkg::wdol_cfg_t cfg;
  int                  ticks = 0, miscompares = 0, n_checks = 0;

  always #10 i_core_clk = ~i_core_clk;

  // reference clock at a quarter of the core rate, counted in ticks
  always @(posedge i_core_clk) begin
    ph <= ph + 2'h1;
    xclk <= ph[1];
    if (ph == 2'h2) ticks <= ticks + 1;
  end

  wdol_top i_dut (.i_core_clk(i_core_clk), .i_rst_b(i_rst_b), .i_por_b(i_por_b), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_crystal_ref_clock(xclk), .i_test_hv_irq(hv_irq),
    .i_test_hv_rst(hv_rst), .i_lvd_trip(trip), .i_reset_vector_lo(8'hA5), .i_stop_instr(stop_instr),
    .i_stop_mode(stop_mode), .i_stop_exit(stop_exit), .i_stop_exit_pin(exit_pin), .i_vector_fetch(vfetch),
    .i_internal_reset(int_rst), .i_monitor_mode(mon), .i_break_state(brk), .i_blank_vectors(blank),
    .o_cfg(cfg), .o_osc_enable(osc_en), .o_serial_clk_is_bus(ser_bus), .o_lvd_power_on(lvd_on),
    .o_lvd_reset_req(lvd_req), .o_cpu_hold(hold), .o_stop_accept(stop_ok), .o_illegal_op_reset(ill),
    .o_wdog_reset(wd_rst), .o_rst_pin_out(pin_out), .o_rst_pin_oe_b(pin_oe_b));

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic we, input logic [15:0] idx, input logic [7:0] d, input logic [3:0] b,
                     output logic [7:0] q);
    int n;
    logic w;
    n = 0;
    w = 1'b1;
    q = 8'h00;
    @(posedge i_core_clk);
    addr  <= {idx, 2'b00};
    rd    <= ~we;
    wr    <= we;
    wdata <= {24'h000000, d};
    be    <= b;
    // look mid-cycle so the edge that ends the access sees settled values
    do begin
      @(negedge i_core_clk);
      w = wreq;
      q = rdata[7:0];
      @(posedge i_core_clk);
      n++;
    end while (w !== 1'b0 && n < 20);
    rd <= 1'b0;
    wr <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic wreg(input logic [15:0] idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, 4'hF, q);
  endtask

  task automatic rreg(input logic [15:0] idx, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, 4'hF, q);
    chk({24'h000000, q}, {24'h000000, exp});
  endtask

  // waits for a level on hold (0), watchdog pulse (1) or pin enable (2); returns ticks spent
  task automatic wait_for(input int w, input logic lvl, input int lim, output int t);
    int n;
    logic s;
    n = 0;
    t = ticks;
    do begin
      @(negedge i_core_clk);
      n++;
      s = (w == 0) ? hold : (w == 1) ? wd_rst : pin_oe_b;
    end while (s !== lvl && n < lim);
    t = ticks - t;
    if (n >= lim) begin
      miscompares++;
      $display("ERROR at %0t: wait limit reached", $time);
      final_report();
    end
  endtask

  task automatic stop_pulse(output logic a, output logic i);
    @(posedge i_core_clk);
    stop_instr <= 1'b1;
    @(posedge i_core_clk);
    stop_instr <= 1'b0;
    @(negedge i_core_clk);
    a = stop_ok;
    i = ill;
  endtask

  task automatic recovery(input logic pin, input int exp, input int lim);
    int t;
    @(posedge i_core_clk);
    exit_pin  <= pin;
    stop_exit <= 1'b1;
    @(posedge i_core_clk);
    stop_exit <= 1'b0;
    wait_for(0, 1'b1, 10, t);
    wait_for(0, 1'b0, lim, t);
    chk({31'h0, (t >= exp - 1 && t <= exp + 1)}, 32'h1);
    exit_pin <= 1'b0;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic s_defaults();
    logic a, i;
    chk({22'h0, cfg}, 32'h0);
    rreg(wdol_pkg::IDX_OPT_TWO, 8'h00);
    rreg(wdol_pkg::IDX_OPT_ONE, 8'h00);
    rreg(wdol_pkg::IDX_CLEAR, 8'hA5);
    rreg(16'h0100, 8'h00);
    stop_pulse(a, i);
    chk({30'h0, a, i}, 32'h1);
  endtask

  task automatic s_write_once();
    logic [7:0] q;
    logic a, i;
    bus(1'b1, wdol_pkg::IDX_OPT_ONE, 8'hFF, 4'h0, q);
    wreg(wdol_pkg::IDX_OPT_ONE, 8'h8E);
    wreg(wdol_pkg::IDX_OPT_ONE, 8'h01);
    wreg(wdol_pkg::IDX_OPT_TWO, 8'h03);
    wreg(wdol_pkg::IDX_OPT_TWO, 8'h00);
    rreg(wdol_pkg::IDX_OPT_ONE, 8'h8E);
    rreg(wdol_pkg::IDX_OPT_TWO, 8'h03);
    chk({31'h0, ser_bus}, 32'h1);
    stop_mode <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    chk({31'h0, osc_en}, 32'h1);
    stop_mode <= 1'b0;
    stop_pulse(a, i);
    chk({30'h0, a, i}, 32'h2);
    recovery(1'b0, 32, 400);
    recovery(1'b1, 4096, 16800);
  endtask

  task automatic s_timeout();
    int t;
    wreg(wdol_pkg::IDX_CLEAR, 8'h5A);
    wait_for(1, 1'b1, 33500, t);
    chk({31'h0, (t >= 8158 && t <= 8180)}, 32'h1);
    wait_for(2, 1'b0, 100, t);
    chk({31'h0, pin_out}, 32'h0);
    wait_for(2, 1'b1, 300, t);
    chk({31'h0, (t >= 31 && t <= 33)}, 32'h1);
    rreg(wdol_pkg::IDX_CAUSE, 8'h01);
  endtask

  task automatic s_after_reset();
    logic seen;
    @(posedge i_core_clk);
    i_rst_b <= 1'b0;
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    rreg(wdol_pkg::IDX_OPT_ONE, 8'h08);
    rreg(wdol_pkg::IDX_OPT_TWO, 8'h00);
    wreg(wdol_pkg::IDX_OPT_ONE, 8'hC1);
    rreg(wdol_pkg::IDX_OPT_ONE, 8'hC9);
    stop_mode <= 1'b1;
    trip      <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    chk({29'h0, lvd_on, osc_en, lvd_req}, 32'h5);
    stop_mode <= 1'b0;
    trip      <= 1'b0;
    wreg(wdol_pkg::IDX_CLEAR, 8'h00);
    seen = 1'b0;
    repeat (33500) begin
      @(posedge i_core_clk);
      if (wd_rst !== 1'b0) seen = 1'b1;
    end
    chk({31'h0, seen}, 32'h0);
  endtask

  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    i_por_b <= 1'b1;
    s_defaults();
    s_write_once();
    s_timeout();
    s_after_reset();
    final_report();
  end
endmodule // wdol_top_tb
`default_nettype wire
